// [wwdc_defines.vh]
`ifndef WWDC_DEFINES_VH
`define WWDC_DEFINES_VH

// Register byte offsets on the APB.
`define WWDC_OFF_RCC       8'h00
`define WWDC_OFF_IRQ_STAT  8'h04
`define WWDC_OFF_IRQ_EN    8'h08
`define WWDC_OFF_IRQ_CLR   8'h0c
`define WWDC_OFF_COUNT     8'h10

// Fields of reset_cause_control_reg.
`define WWDC_RCC_SWEN      5
`define WWDC_RCC_TOFLAG    4
`define WWDC_RCC_SLEEP     3
`define WWDC_RCC_IDLE      2

// Interrupt status, enable and clear layout.
`define WWDC_IRQ_TIMEOUT   0
`define WWDC_IRQ_EARLY     1
`define WWDC_IRQ_WAKE      2
`define WWDC_IRQ_W         3

// Reset values.
`define WWDC_RST_RCC       6'h00
`define WWDC_RST_IRQ       3'h0

// Hardware enable field encodings.
`define WWDC_HW_OFF        2'h0
`define WWDC_HW_RUNIDLE    2'h1
`define WWDC_HW_SOFT       2'h2
`define WWDC_HW_ALWAYS     2'h3

// Time base: prescaler cycles per tick and postscaler ticks per period.
`define WWDC_PRE_W         5
`define WWDC_PRE_LAST      5'h1f
`define WWDC_POST_W        7
`define WWDC_POST_LAST     7'h7f
// The window opens after three quarters of the period have elapsed.
`define WWDC_WIN_START     7'h60

`endif

// [wwdc_timebase.v]
`timescale 1ns/1ps
`include "wwdc_defines.vh"

module wwdc_timebase (
   input  wire                    sys_clk,
   input  wire                    srst,
   input  wire                    run,
   input  wire                    clear,
   output wire                    timeout,
   output wire                    in_window,
   output wire [`WWDC_POST_W-1:0] post_count
);

   reg [`WWDC_PRE_W-1:0]  pre_q;
   reg [`WWDC_POST_W-1:0] post_q;
   wire                   tick;

   assign tick       = run && (pre_q == `WWDC_PRE_LAST);
   assign timeout    = tick && (post_q == `WWDC_POST_LAST) && !clear;
   assign in_window  = (post_q >= `WWDC_WIN_START);
   assign post_count = post_q;

   always @(posedge sys_clk) begin
      if (srst || clear) begin
         pre_q  <= {`WWDC_PRE_W{1'b0}};
         post_q <= {`WWDC_POST_W{1'b0}};
      end else if (run) begin
         pre_q <= pre_q + 1'b1;
         if (tick) begin
            post_q <= post_q + 1'b1;
         end
      end
   end

endmodule // wwdc_timebase

// [wwdc_top.v]
// Function
// - Hardware enable 11 keeps counting in Sleep/Idle; time-out there wakes, not resets.
// - Each time-out sets a sticky flag; only software or srst clears it.
// - Clear or power-save instruction zeroes prescaler and postscaler counts.
// - Windowed mode: a clear restarts the count only in the last quarter.
// - Windowed mode: a clear before the window causes a watchdog reset.
// - Window-disable bit zero selects windowed mode; one selects normal mode.
// - Hardware enable 11 keeps the watchdog on regardless of software enable.
// - Hardware enable 10 runs the watchdog exactly while software enable is set.
// - Software enable returns to zero on every device reset.
// - Hardware enable 01 runs in Run and Idle, stops in Sleep.
// - Hardware enable 01 ignores software enable writes.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "wwdc_defines.vh"

module wwdc_top (
   input  wire        sys_clk,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output wire [31:0] prdata,
   input  wire [1:0]  wdt_hw_enable_field,
   input  wire        window_mode_disable,
   input  wire        watchdog_clear_instr,
   input  wire        power_save_instr,
   input  wire        power_save_sleep,
   input  wire        ext_wake,
   output wire        wdt_reset_req,
   output wire        wdt_wake,
   output wire [1:0]  power_state,
   output wire        irq
);

   localparam ST_RUN   = 2'd0;
   localparam ST_IDLE  = 2'd1;
   localparam ST_SLEEP = 2'd2;

   localparam SEL_NONE = 3'd0;
   localparam SEL_RCC  = 3'd1;
   localparam SEL_STAT = 3'd2;
   localparam SEL_EN   = 3'd3;
   localparam SEL_CLR  = 3'd4;
   localparam SEL_CNT  = 3'd5;

   reg [1:0]             state_q;
   reg [1:0]             state_d;
   reg                   swen_q;
   reg                   toflag_q;
   reg                   sleep_st_q;
   reg                   idle_st_q;
   reg [`WWDC_IRQ_W-1:0] stat_q;
   reg [`WWDC_IRQ_W-1:0] en_q;
   reg [31:0]            prdata_q;
   reg                   reset_q;
   reg                   wake_q;
   reg                   run;
   reg [31:0]            rdata;

   wire                    setup;
   wire                    wr;
   wire [2:0]              sel_rd;
   wire [2:0]              sel_wr;
   wire                    timeout;
   wire                    in_window;
   wire [`WWDC_POST_W-1:0] post_count;
   wire                    powersave;
   wire                    windowed;
   wire                    early_clear;
   wire                    to_wake;
   wire                    to_reset;
   wire                    tb_clear;
   wire [`WWDC_IRQ_W-1:0]  events;

   function [2:0] reg_sel;
      input [7:0] addr;
      begin
         case (addr)
            `WWDC_OFF_RCC:      reg_sel = SEL_RCC;
            `WWDC_OFF_IRQ_STAT: reg_sel = SEL_STAT;
            `WWDC_OFF_IRQ_EN:   reg_sel = SEL_EN;
            `WWDC_OFF_IRQ_CLR:  reg_sel = SEL_CLR;
            `WWDC_OFF_COUNT:    reg_sel = SEL_CNT;
            default:            reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   // APB slave with no wait states; read data is latched in the setup cycle.
   // Latching in setup means a read returns the state seen one cycle before
   // the access phase, which is early enough for every status bit here.
   assign setup   = psel && !penable;
   assign wr      = psel && penable && pwrite;
   assign sel_rd  = reg_sel(paddr);
   assign sel_wr  = reg_sel(paddr);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (sel_rd == SEL_NONE);
   assign prdata  = prdata_q;

   assign powersave = (state_q != ST_RUN);

   // Run enable follows the hardware enable field and the power state.
   always @* begin
      case (wdt_hw_enable_field)
         `WWDC_HW_ALWAYS:  run = 1'b1;
         `WWDC_HW_SOFT:    run = swen_q;
         `WWDC_HW_RUNIDLE: run = (state_q != ST_SLEEP);
         default:          run = 1'b0;
      endcase
   end

   assign windowed    = !window_mode_disable;
   assign early_clear = windowed && run && watchdog_clear_instr &&
                        !in_window;
   // A clear outside the window in windowed mode does not restart while the watchdog runs.
   assign tb_clear    = power_save_instr ||
                        (watchdog_clear_instr && !early_clear);
   assign to_wake     = timeout && powersave;
   assign to_reset    = (timeout && !powersave) || early_clear;

   assign events[`WWDC_IRQ_TIMEOUT] = timeout;
   assign events[`WWDC_IRQ_EARLY]   = early_clear;
   assign events[`WWDC_IRQ_WAKE]    = to_wake;

   wwdc_timebase u_timebase (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .run        (run),
      .clear      (tb_clear),
      .timeout    (timeout),
      .in_window  (in_window),
      .post_count (post_count)
   );

   // Power state of the core as seen by the watchdog.
   // A time-out while halted returns the core to run in the same cycle in
   // which the wake pulse is launched, so execution resumes after the
   // power-save instruction instead of restarting.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (power_save_instr) begin
               state_d = power_save_sleep ? ST_SLEEP : ST_IDLE;
            end
         end
         ST_IDLE, ST_SLEEP: begin
            if (to_wake || ext_wake) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         state_q <= ST_RUN;
         reset_q <= 1'b0;
         wake_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         reset_q <= to_reset;
         wake_q  <= to_wake;
      end
   end

   // Reset cause and control bits; hardware set wins over software clear.
   always @(posedge sys_clk) begin
      if (srst) begin
         swen_q     <= 1'b0;
         toflag_q   <= 1'b0;
         sleep_st_q <= 1'b0;
         idle_st_q  <= 1'b0;
      end else begin
         if (wr && sel_wr == SEL_RCC) begin
            swen_q     <= pwdata[`WWDC_RCC_SWEN];
            toflag_q   <= pwdata[`WWDC_RCC_TOFLAG];
            sleep_st_q <= pwdata[`WWDC_RCC_SLEEP];
            idle_st_q  <= pwdata[`WWDC_RCC_IDLE];
         end
         if (timeout || early_clear) begin
            toflag_q <= 1'b1;
         end
         if (power_save_instr && state_q == ST_RUN) begin
            if (power_save_sleep) begin
               sleep_st_q <= 1'b1;
            end else begin
               idle_st_q <= 1'b1;
            end
         end
      end
   end

   // Interrupt status, enable and write-one-to-clear.
   always @(posedge sys_clk) begin
      if (srst) begin
         stat_q <= `WWDC_RST_IRQ;
         en_q   <= `WWDC_RST_IRQ;
      end else begin
         if (wr && sel_wr == SEL_EN) begin
            en_q <= pwdata[`WWDC_IRQ_W-1:0];
         end
         if (wr && sel_wr == SEL_CLR) begin
            stat_q <= (stat_q & ~pwdata[`WWDC_IRQ_W-1:0]) | events;
         end else begin
            stat_q <= stat_q | events;
         end
      end
   end

   assign irq = |(stat_q & en_q);

   always @* begin
      rdata = 32'h0000_0000;
      case (sel_rd)
         SEL_RCC: begin
            rdata[`WWDC_RCC_SWEN]   = swen_q;
            rdata[`WWDC_RCC_TOFLAG] = toflag_q;
            rdata[`WWDC_RCC_SLEEP]  = sleep_st_q;
            rdata[`WWDC_RCC_IDLE]   = idle_st_q;
         end
         SEL_STAT: rdata[`WWDC_IRQ_W-1:0] = stat_q;
         SEL_EN:   rdata[`WWDC_IRQ_W-1:0] = en_q;
         SEL_CNT: begin
            rdata[`WWDC_POST_W-1:0] = post_count;
            rdata[8]                = run;
            rdata[9]                = in_window;
         end
         default:  rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_q <= rdata;
      end
   end

   assign wdt_reset_req = reset_q;
   assign wdt_wake      = wake_q;
   assign power_state   = state_q;

endmodule // wwdc_top

// [wwdc_props.sv]
`timescale 1ns/1ps
module wwdc_props (
   input wire       sys_clk,
   input wire       srst,
   input wire [1:0] wdt_hw_enable_field,
   input wire       window_mode_disable,
   input wire       watchdog_clear_instr,
   input wire       power_save_instr,
   input wire       power_save_sleep,
   input wire       wdt_reset_req,
   input wire       wdt_wake,
   input wire [1:0] power_state
);
   wire [1:0] hw = wdt_hw_enable_field;
   wire [1:0] ps = power_state;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   chk_off_quiet: assert property (
      hw == 2'h0 && $past(hw) == 2'h0 |-> !wdt_reset_req && !wdt_wake)
      else $error("Disabled watchdog fired.");
   chk_wake_resume: assert property (
      wdt_wake |-> ps == 2'h0 && $past(ps) != 2'h0)
      else $error("Wake without return to run.");
   chk_sleep_stop: assert property (
      wdt_wake |-> !($past(hw) == 2'h1 && $past(ps) == 2'h2))
      else $error("Watchdog ran in sleep.");
   chk_wake_pulse: assert property (
      $rose(wdt_wake) |=> $fell(wdt_wake))
      else $error("Wake pulse too long.");
   chk_reset_run: assert property (
      wdt_reset_req |-> $past(ps) == 2'h0)
      else $error("Reset request outside run.");
   chk_reset_pulse: assert property (
      wdt_reset_req |=> (!wdt_reset_req) [*4])
      else $error("Reset request repeated.");
   chk_ps_enter: assert property (
      power_save_instr && ps == 2'h0
      |=> ps == ($past(power_save_sleep) ? 2'h2 : 2'h1))
      else $error("Wrong power state entered.");
   chk_nowin_clear: assert property (
      watchdog_clear_instr && window_mode_disable |=> !wdt_reset_req)
      else $error("Clear punished outside windowed mode.");
endmodule // wwdc_props

// [wwdc_core_model.sv]
`timescale 1ns/1ps
module wwdc_core_model (
   input  wire       sys_clk,
   input  wire       clr_cmd,
   input  wire       ps_cmd,
   input  wire       ps_sleep,
   input  wire [1:0] power_state,
   output reg        watchdog_clear_instr = 1'b0,
   output reg        power_save_instr = 1'b0,
   output reg        power_save_sleep = 1'b0
);
   // A halted core issues nothing; the sleep select wanders when unused.
   always @(posedge sys_clk) begin
      watchdog_clear_instr <= clr_cmd && power_state == 2'h0;
      power_save_instr     <= ps_cmd && power_state == 2'h0;
      power_save_sleep     <= ps_cmd ? ps_sleep : ~power_save_sleep;
   end
endmodule // wwdc_core_model

// [tb_windowed_watchdog_control.sv]
`timescale 1ns/1ps
module tb_windowed_watchdog_control;
   reg         sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   reg         pwrite = 1'b0, window_mode_disable = 1'b1, ext_wake = 1'b0;
   reg         clr_cmd = 1'b0, ps_cmd = 1'b0, ps_sleep = 1'b0, err;
   reg  [1:0]  wdt_hw_enable_field = 2'h3;
   reg  [7:0]  paddr = 8'h00;
   reg  [15:0] lfsr = 16'h22c1;
   reg  [31:0] pwdata = 32'h0, rd;
   wire        pready, pslverr, wdt_reset_req, wdt_wake, irq;
   wire        watchdog_clear_instr, power_save_instr, power_save_sleep;
   wire [1:0]  power_state;
   wire [31:0] prdata;
   integer     fails = 0, tests_run = 0, cyc, s;
   always #50 sys_clk = ~sys_clk;
   wwdc_top i_wwdc_top (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .wdt_hw_enable_field,
      .window_mode_disable, .watchdog_clear_instr, .power_save_instr,
      .power_save_sleep, .ext_wake, .wdt_reset_req, .wdt_wake, .power_state,
      .irq);
   wwdc_core_model i_wwdc_core_model (.sys_clk, .clr_cmd, .ps_cmd,
      .ps_sleep, .power_state, .watchdog_clear_instr, .power_save_instr,
      .power_save_sleep);
   function [15:0] lfsr_next(input [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task results;
      begin
         $display("comparisons %0d, mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task check(input ok, input [8*16:1] msg);
      begin
         tests_run = tests_run + 1;
         if (ok !== 1'b1) begin
            fails = fails + 1;
            $display("MISMATCH at %0t: %0s", $time, msg);
         end
      end
   endtask
   task done(input [8*8:1] n);
      $display("test %0s finished", n);
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
         @(posedge sys_clk);
         penable <= 1'b1;
         n = 0;
         @(posedge sys_clk);
         while (pready !== 1'b1 && n < 16) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         rd = prdata;
         err = pslverr;
         {psel, penable} <= 2'b00;
         if (n == 16) begin
            check(1'b0, "apb hang");
            results;
         end
         @(posedge sys_clk);
      end
   endtask
   task issue(input c, input p, input sl);
      begin
         {clr_cmd, ps_cmd, ps_sleep} <= {c, p, sl};
         @(posedge sys_clk);
         {clr_cmd, ps_cmd} <= 2'b00;
         @(posedge sys_clk);
      end
   endtask
   task wait_evt(input integer lim);
      begin
         cyc = 0;
         while (wdt_reset_req !== 1'b1 && wdt_wake !== 1'b1 && cyc < lim) begin
            @(posedge sys_clk);
            cyc = cyc + 1;
         end
      end
   endtask
   task expect_evt(input integer lo, input integer hi);
      begin
         wait_evt(hi + 1);
         check(cyc >= lo && cyc <= hi, "event time");
         if (cyc > hi)
            results;
      end
   endtask
   task do_reset;
      begin
         srst <= 1'b1;
         repeat (3) @(posedge sys_clk);
         srst <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   initial begin
      do_reset;
      apb(1'b0, 8'h00, 32'h0);
      check(rd === 32'h0, "rcc reset");
      apb(1'b0, 8'h20, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped");
      apb(1'b1, 8'h08, 32'h1);
      lfsr = lfsr_next(lfsr);
      repeat (1000 + lfsr[10:0]) @(posedge sys_clk);
      issue(1'b1, 1'b0, 1'b0);
      expect_evt(4090, 4100);
      check(wdt_reset_req === 1'b1 && irq === 1'b1, "run timeout");
      apb(1'b0, 8'h04, 32'h0);
      check(rd === 32'h1, "stat timeout");
      apb(1'b0, 8'h10, 32'h0);
      check(rd[9:8] === 2'b01 && err === 1'b0, "count status");
      lfsr = lfsr_next(lfsr);
      apb(1'b1, 8'h04, {16'h0, lfsr});
      apb(1'b0, 8'h04, 32'h0);
      check(rd === 32'h1 && err === 1'b0, "stat read only");
      apb(1'b1, 8'h24, {16'h0, lfsr});
      check(err === 1'b1, "unmapped write");
      repeat (20) @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      check(rd[4] === 1'b1, "flag sticky");
      apb(1'b1, 8'h08, 32'h0);
      check(irq === 1'b0, "irq mask");
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h0c, 32'h1);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      check(irq === 1'b0 && rd === 32'h0, "flag clear");
      done("run");
      window_mode_disable <= 1'b0;
      do_reset;
      lfsr = lfsr_next(lfsr);
      repeat (100 + lfsr[9:0]) @(posedge sys_clk);
      issue(1'b1, 1'b0, 1'b0);
      expect_evt(1, 3);
      check(wdt_reset_req === 1'b1, "early clear");
      do_reset;
      lfsr = lfsr_next(lfsr);
      repeat (3100 + lfsr[9:0] % 900) @(posedge sys_clk);
      issue(1'b1, 1'b0, 1'b0);
      expect_evt(4090, 4100);
      window_mode_disable <= 1'b1;
      done("window");
      for (s = 1; s >= 0; s = s - 1) begin
         do_reset;
         issue(1'b0, 1'b1, s[0]);
         @(posedge sys_clk);
         check(power_state === (s ? 2'h2 : 2'h1), "enter");
         expect_evt(4090, 4100);
         check(wdt_wake === 1'b1 && power_state === 2'h0, "wake");
         apb(1'b0, 8'h00, 32'h0);
         check(rd[5:2] === (s ? 4'h6 : 4'h5), "status kept");
      end
      done("sleep");
      wdt_hw_enable_field <= 2'h1;
      do_reset;
      issue(1'b0, 1'b1, 1'b0);
      expect_evt(4090, 4100);
      check(wdt_wake === 1'b1, "idle wake");
      issue(1'b0, 1'b1, 1'b1);
      wait_evt(5000);
      check(cyc === 5000, "sleep stop");
      ext_wake <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_wake <= 1'b0;
      check(power_state === 2'h0, "ext wake");
      done("runidle");
      wdt_hw_enable_field <= 2'h2;
      do_reset;
      wait_evt(5000);
      check(cyc === 5000, "soft off");
      apb(1'b1, 8'h00, 32'h20);
      expect_evt(4085, 4100);
      do_reset;
      apb(1'b0, 8'h00, 32'h0);
      check(rd === 32'h0, "swen reset");
      wdt_hw_enable_field <= 2'h0;
      apb(1'b1, 8'h00, 32'h20);
      wait_evt(5000);
      check(cyc === 5000, "hw off");
      done("soft");
      results;
   end
endmodule // tb_windowed_watchdog_control
bind wwdc_top wwdc_props i_wwdc_props (.sys_clk, .srst, .wdt_hw_enable_field,
   .window_mode_disable, .watchdog_clear_instr, .power_save_instr,
   .power_save_sleep, .wdt_reset_req, .wdt_wake, .power_state);
